// ---- pkg/asl_regs.svh ----
// Purpose: named constants for the axis stroke limit checker
// Assumes: 32-bit positions, degree unit counted in 0.00001 degree steps
// Notes:   definitions only, no logic
`ifndef ASL_REGS_SVH
`define ASL_REGS_SVH

// ****************************************************************
// widths and reset values
// ****************************************************************
`define ASL_POS_W        32
`define ASL_UPPER_RST    32'sh7fffffff
`define ASL_LOWER_RST    32'sh80000000
// one full turn; 359.99999 degrees is the last ring address
`define ASL_RING_TURN    32'sh0225_5100
`define ASL_ZERO_POS     32'sh0000_0000

// ****************************************************************
// setting encodings
// ****************************************************************
`define ASL_MCE_APPLIED  1'b0
`define ASL_SRC_FEED     1'b0
`define ASL_LOGIC_NEG    1'b0

`endif

// ---- pkg/asl_pkg.sv ----
// Purpose: types shared by the stroke limit checker and its users
// Assumes: asl_regs.svh included for widths
// Notes:   one parameter set per axis
`include "asl_regs.svh"

package asl_pkg;

  // ****************************************************************
  // control kinds requested at start
  // ****************************************************************
  typedef enum logic [2:0] {
    ASL_K_ORIGIN,
    ASL_K_POSITION,
    ASL_K_SPEED,
    ASL_K_CIRCULAR,
    ASL_K_CONTPATH,
    ASL_K_MANUAL
  } asl_kind_t;

  // ****************************************************************
  // stroke limit parameter set of one axis
  // ****************************************************************
  typedef struct packed {
    logic signed [`ASL_POS_W-1:0] upper_bound_param;
    logic signed [`ASL_POS_W-1:0] lower_bound_param;
    logic                         bound_source_select;
    logic                         manual_check_enable;
    logic                         feed_value_update_in_speed_ctrl;
    logic                         input_logic_upper;
    logic                         input_logic_lower;
    logic                         unit_degree;
  } asl_param_t;

  // ****************************************************************
  // start request carrier
  // ****************************************************************
  typedef struct packed {
    logic      req;
    asl_kind_t kind;
    logic      dir_pos;
  } asl_start_t;

endpackage

// ---- src/asl_checker.sv ----
// Purpose: per-axis software and hardware stroke limit supervision
// Assumes: host_ready_i, requests and feed steps come from the same clock
// Notes:   limit switch pins are synchronised before use
//
// Overview of operation
// R1 - interpolation checks every axis, none starts on failure
// R2 - simultaneous start checks all, any failure blocks all
// R3 - circular interpolation never stops on software bound
// R4 - continuous path stops after the preceding entry
// R5 - parameters adopted only on host ready rise
// R6 - upper bound resets to max positive
// R7 - lower bound resets to most negative
// R8 - skip check when feed frozen in speed
// R9 - manual check enable, zero means applied
// R10 - equal bounds disable software check entirely
// R11 - invalid setting skips only manual checks
// R12 - degree unit skips speed and manual checks
// R13 - degree feed value wraps within one turn
// R14 - degree range runs clockwise lower to upper
// R15 - active limit switch forces deceleration stop
// R16 - after limit stop only manual moves start
// R17 - negative logic refuses on disconnected inputs
// R18 - positive logic permits unwired limit inputs
// R19 - host does origin return before trusting bounds
// R20 - independent parameter set per axis
// R21 - speed decelerates, position stops at once
// R22 - reject out of range value change
// R23 - manual outside range only moves back
// R24 - limit inputs pass two register stages
`include "asl_regs.svh"
`timescale 1ns/10ps
`default_nettype none

module asl_checker #(
  parameter int NUM_AXES = 4
) (
  input  wire logic                                     clock_i,
  input  wire logic                                     rst_i,
  input  wire logic                                     ce_i,
  input  wire logic                                     host_ready_i,
  input  wire asl_pkg::asl_param_t [NUM_AXES-1:0]       param_i,
  input  wire logic [NUM_AXES-1:0]                      upper_limit_input_i,
  input  wire logic [NUM_AXES-1:0]                      lower_limit_input_i,
  input  wire asl_pkg::asl_start_t                      start_i,
  input  wire logic [NUM_AXES-1:0]                      start_axes_i,
  input  wire logic [NUM_AXES-1:0]                      speed_phase_i,
  input  wire logic [NUM_AXES-1:0]                      entry_done_i,
  input  wire logic [NUM_AXES-1:0]                      run_end_i,
  input  wire logic [NUM_AXES-1:0][`ASL_POS_W-1:0]      feed_step_i,
  input  wire logic                                     chg_req_i,
  input  wire logic [$clog2(NUM_AXES)-1:0]              chg_axis_i,
  input  wire logic [`ASL_POS_W-1:0]                    chg_value_i,
  output logic                                          start_ok_o,
  output logic                                          start_err_o,
  output logic                                          chg_ok_o,
  output logic                                          chg_err_o,
  output logic [NUM_AXES-1:0]                           running_o,
  output logic [NUM_AXES-1:0]                           decel_stop_o,
  output logic [NUM_AXES-1:0]                           imm_stop_o,
  output logic [NUM_AXES-1:0]                           limit_hold_o,
  output logic [NUM_AXES-1:0][`ASL_POS_W-1:0]           current_feed_value_o
);
  import asl_pkg::*;

  // ****************************************************************
  // state
  // ****************************************************************
  typedef struct packed {
    asl_param_t                   act;
    logic signed [`ASL_POS_W-1:0] feed;
    logic                         running;
    asl_kind_t                    kind;
    logic                         dir_pos;
    logic                         pend_stop;
    logic                         lim_flag;
    logic                         decel;
    logic                         imm;
    logic [1:0]                   lim_s1;
    logic [1:0]                   lim_s2;
  } asl_axis_t;

  typedef struct packed {
    asl_axis_t [NUM_AXES-1:0] ax;
    logic                     ready_d;
    logic                     start_ok;
    logic                     start_err;
    logic                     chg_ok;
    logic                     chg_err;
  } asl_state_t;

  asl_state_t st_reg;
  asl_state_t st_next;
  logic [NUM_AXES-1:0] lim_up_act;
  logic [NUM_AXES-1:0] lim_lo_act;

  // ****************************************************************
  // helpers
  // ****************************************************************
  // equal bounds switch the whole software check off
  function automatic logic sw_off(input asl_param_t p);
    sw_off = (p.upper_bound_param == p.lower_bound_param); // [R10]
  endfunction

  function automatic logic in_range(input asl_param_t p,
                                    input logic signed [`ASL_POS_W-1:0] v);
    if (sw_off(p)) begin
      in_range = 1'b1;
    end else if (p.unit_degree && (p.lower_bound_param > p.upper_bound_param)) begin
      // clockwise span crossing the zero address [R14]
      in_range = (v >= p.lower_bound_param) || (v <= p.upper_bound_param);
    end else begin
      in_range = (v >= p.lower_bound_param) && (v <= p.upper_bound_param);
    end
  endfunction

  // does the software check apply to this kind of control
  function automatic logic applies(input asl_param_t p, input asl_kind_t k,
                                   input logic spd);
    applies = 1'b1;
    if (k == ASL_K_ORIGIN) begin
      applies = 1'b0;
    end else if (k == ASL_K_MANUAL) begin
      // [R9] [R11] [R12]
      applies = (p.manual_check_enable == `ASL_MCE_APPLIED) && !p.unit_degree;
    end else if (k == ASL_K_SPEED || spd) begin
      if (p.unit_degree) begin
        applies = 1'b0; // [R12]
      end else if (p.bound_source_select == `ASL_SRC_FEED &&
                   !p.feed_value_update_in_speed_ctrl) begin
        applies = 1'b0; // [R8]
      end
    end
    if (sw_off(p)) begin
      applies = 1'b0; // [R10]
    end
  endfunction

  // ****************************************************************
  // limit input logic, applied to second stage only
  // ****************************************************************
  // unwired pin reads low, so negative logic sees it as active [R17] [R18]
  always_comb begin
    for (int a = 0; a < NUM_AXES; a++) begin
      lim_up_act[a] = (st_reg.ax[a].act.input_logic_upper == `ASL_LOGIC_NEG) ?
                      !st_reg.ax[a].lim_s2[1] : st_reg.ax[a].lim_s2[1];
      lim_lo_act[a] = (st_reg.ax[a].act.input_logic_lower == `ASL_LOGIC_NEG) ?
                      !st_reg.ax[a].lim_s2[0] : st_reg.ax[a].lim_s2[0];
    end
  end

  // ****************************************************************
  // next state
  // ****************************************************************
  always_comb begin
    logic                         fail;
    logic                         bad;
    logic                         spd;
    logic signed [`ASL_POS_W-1:0] nv;
    fail    = 1'b0;
    bad     = 1'b0;
    spd     = 1'b0;
    nv      = `ASL_ZERO_POS;
    st_next = st_reg;
    st_next.ready_d   = host_ready_i;
    st_next.start_ok  = 1'b0;
    st_next.start_err = 1'b0;
    st_next.chg_ok    = 1'b0;
    st_next.chg_err   = 1'b0;

    // pin synchronisers and per-axis supervision
    for (int a = 0; a < NUM_AXES; a++) begin
      st_next.ax[a].lim_s1 = {upper_limit_input_i[a], lower_limit_input_i[a]}; // [R24]
      st_next.ax[a].lim_s2 = st_reg.ax[a].lim_s1; // [R24]
      st_next.ax[a].decel  = 1'b0;
      st_next.ax[a].imm    = 1'b0;
      // new settings only at the host ready rise [R5] [R20]
      if (host_ready_i && !st_reg.ready_d) begin
        st_next.ax[a].act = param_i[a]; // [R5]
      end

      if (st_reg.ax[a].running) begin
        // feed advance; degree unit keeps a ring address [R13]
        nv = st_reg.ax[a].feed + $signed(feed_step_i[a]);
        if (st_reg.ax[a].act.unit_degree) begin
          if (nv >= `ASL_RING_TURN) begin
            nv = nv - `ASL_RING_TURN; // [R13]
          end else if (nv < `ASL_ZERO_POS) begin
            nv = nv + `ASL_RING_TURN; // [R13]
          end
        end
        st_next.ax[a].feed = nv;

        spd = speed_phase_i[a] || st_reg.ax[a].kind == ASL_K_SPEED;
        // circular moves may overshoot without stopping [R3]
        bad = applies(st_reg.ax[a].act, st_reg.ax[a].kind, speed_phase_i[a]) &&
              st_reg.ax[a].kind != ASL_K_CIRCULAR &&
              !in_range(st_reg.ax[a].act, st_reg.ax[a].feed);
        // a manual move heading back toward the range must not be stopped [R23]
        if (st_reg.ax[a].kind == ASL_K_MANUAL &&
            ((st_reg.ax[a].feed > st_reg.ax[a].act.upper_bound_param) !=
             st_reg.ax[a].dir_pos)) begin
          bad = 1'b0; // [R23]
        end

        if ((st_reg.ax[a].kind != ASL_K_MANUAL && (lim_up_act[a] || lim_lo_act[a])) ||
            (st_reg.ax[a].kind == ASL_K_MANUAL &&
             ((lim_up_act[a] && st_reg.ax[a].dir_pos) ||
              (lim_lo_act[a] && !st_reg.ax[a].dir_pos)))) begin
          // manual recovery away from a switch is left running
          st_next.ax[a].decel    = 1'b1; // [R15]
          st_next.ax[a].running  = 1'b0;
          st_next.ax[a].lim_flag = 1'b1; // [R16]
        end else if (st_reg.ax[a].pend_stop && entry_done_i[a]) begin
          st_next.ax[a].imm       = 1'b1; // [R4]
          st_next.ax[a].running   = 1'b0;
          st_next.ax[a].pend_stop = 1'b0;
        end else if (bad && st_reg.ax[a].kind == ASL_K_CONTPATH) begin
          st_next.ax[a].pend_stop = 1'b1; // [R4]
        end else if (bad) begin
          if (spd || st_reg.ax[a].kind == ASL_K_MANUAL) begin
            st_next.ax[a].decel = 1'b1; // [R21]
          end else begin
            st_next.ax[a].imm = 1'b1; // [R21]
          end
          st_next.ax[a].running = 1'b0;
        end else if (run_end_i[a]) begin
          st_next.ax[a].running   = 1'b0;
          st_next.ax[a].pend_stop = 1'b0;
          // a finished manual move with both switches clear ends the hold
          if (st_reg.ax[a].kind == ASL_K_MANUAL && !lim_up_act[a] && !lim_lo_act[a]) begin
            st_next.ax[a].lim_flag = 1'b0; // [R16]
          end
        end
      end
    end

    // start: every axis in the set is checked, one failure blocks all
    if (start_i.req) begin
      for (int a = 0; a < NUM_AXES; a++) begin
        if (start_axes_i[a]) begin
          if (st_reg.ax[a].running) begin
            fail = 1'b1;
          end
          if (start_i.kind != ASL_K_MANUAL &&
              (lim_up_act[a] || lim_lo_act[a] || st_reg.ax[a].lim_flag)) begin
            fail = 1'b1; // [R16] [R17]
          end
          if (applies(st_reg.ax[a].act, start_i.kind, speed_phase_i[a]) &&
              !in_range(st_reg.ax[a].act, st_reg.ax[a].feed)) begin
            if (start_i.kind == ASL_K_MANUAL) begin
              // outside: only the direction back toward the range [R23]
              if ((st_reg.ax[a].feed > st_reg.ax[a].act.upper_bound_param) ==
                  start_i.dir_pos) begin
                fail = 1'b1; // [R23]
              end
            end else begin
              fail = 1'b1; // [R1] [R2]
            end
          end
        end
      end
      if (fail || start_axes_i == '0) begin
        st_next.start_err = 1'b1; // [R1] [R2]
      end else begin
        st_next.start_ok = 1'b1;
        for (int a = 0; a < NUM_AXES; a++) begin
          if (start_axes_i[a]) begin
            st_next.ax[a].running   = 1'b1;
            st_next.ax[a].kind      = start_i.kind;
            st_next.ax[a].dir_pos   = start_i.dir_pos;
            st_next.ax[a].pend_stop = 1'b0;
          end
        end
      end
    end

    // current value change, refused while moving or out of range [R22]
    if (chg_req_i) begin
      if (st_reg.ax[chg_axis_i].running ||
          !in_range(st_reg.ax[chg_axis_i].act, $signed(chg_value_i)) ||
          (st_reg.ax[chg_axis_i].act.unit_degree &&
           ($signed(chg_value_i) < `ASL_ZERO_POS ||
            $signed(chg_value_i) >= `ASL_RING_TURN))) begin
        st_next.chg_err = 1'b1; // [R22]
      end else begin
        st_next.chg_ok = 1'b1;
        st_next.ax[chg_axis_i].feed = $signed(chg_value_i);
      end
    end
  end

  // ****************************************************************
  // registers, frozen while ce_i is low
  // ****************************************************************
  always_ff @(posedge clock_i or posedge rst_i) begin
    if (rst_i) begin
      st_reg <= '0;
      for (int a = 0; a < NUM_AXES; a++) begin
        st_reg.ax[a].act.upper_bound_param <= `ASL_UPPER_RST; // [R6]
        st_reg.ax[a].act.lower_bound_param <= `ASL_LOWER_RST; // [R7]
      end
    end else if (ce_i) begin
      st_reg <= st_next;
    end
  end

  // ****************************************************************
  // outputs
  // ****************************************************************
  assign start_ok_o  = st_reg.start_ok;
  assign start_err_o = st_reg.start_err;
  assign chg_ok_o    = st_reg.chg_ok;
  assign chg_err_o   = st_reg.chg_err;
  always_comb begin
    for (int a = 0; a < NUM_AXES; a++) begin
      running_o[a]            = st_reg.ax[a].running;
      decel_stop_o[a]         = st_reg.ax[a].decel;
      imm_stop_o[a]           = st_reg.ax[a].imm;
      limit_hold_o[a]         = st_reg.ax[a].lim_flag;
      current_feed_value_o[a] = st_reg.ax[a].feed;
    end
  end

  // ****************************************************************
  // assertions on axis 0
  // ****************************************************************
  default clocking cb @(posedge clock_i); endclocking
  default disable iff (rst_i);

  a_param_hold_steady: assert property (ce_i && !(host_ready_i && !st_reg.ready_d)
    |=> $stable(st_reg.ax[0].act)) else $error("parameters changed without ready rise"); // [R5]
  a_param_load_rise: assert property (ce_i && host_ready_i && !st_reg.ready_d
    |=> st_reg.ax[0].act == $past(param_i[0])) else $error("parameters not adopted"); // [R5]
  a_limit_decel_stop: assert property (ce_i && st_reg.ax[0].running && lim_up_act[0] &&
    st_reg.ax[0].kind != ASL_K_MANUAL |=> decel_stop_o[0] && !running_o[0])
    else $error("limit switch did not stop axis"); // [R15]
  a_limit_start_refused: assert property (ce_i && start_i.req && start_axes_i[0] &&
    start_i.kind != ASL_K_MANUAL && (lim_lo_act[0] || limit_hold_o[0])
    |=> start_err_o && !start_ok_o) else $error("start accepted at limit"); // [R16]
  a_circ_no_stop: assert property (ce_i && st_reg.ax[0].running &&
    st_reg.ax[0].kind == ASL_K_CIRCULAR && !lim_up_act[0] && !lim_lo_act[0]
    |=> !imm_stop_o[0] && !decel_stop_o[0]) else $error("circular move stopped"); // [R3]
  a_equal_bounds_off: assert property (ce_i && st_reg.ax[0].running &&
    sw_off(st_reg.ax[0].act) && st_reg.ax[0].kind == ASL_K_POSITION &&
    !st_reg.ax[0].pend_stop |=> !imm_stop_o[0]) else $error("stop with bounds off"); // [R10]
  a_chg_reject_hold: assert property (ce_i && chg_req_i && chg_axis_i == '0 &&
    !in_range(st_reg.ax[0].act, $signed(chg_value_i)) && !st_reg.ax[0].running
    |=> chg_err_o && $stable(current_feed_value_o[0]))
    else $error("bad value change taken"); // [R22]
  a_ring_in_turn: assert property (st_reg.ax[0].act.unit_degree && st_reg.ax[0].running
    && $signed(feed_step_i[0]) < `ASL_RING_TURN && $signed(feed_step_i[0]) > -`ASL_RING_TURN
    && st_reg.ax[0].feed >= `ASL_ZERO_POS && st_reg.ax[0].feed < `ASL_RING_TURN && ce_i
    |=> st_reg.ax[0].feed >= `ASL_ZERO_POS && st_reg.ax[0].feed < `ASL_RING_TURN)
    else $error("degree feed left the ring"); // [R13]
  a_refused_none_start: assert property (ce_i && start_i.req && start_axes_i[0] &&
    !st_reg.ax[0].running |=> start_err_o |-> !running_o[0])
    else $error("axis started on refused start"); // [R2]
  a_contpath_late_stop: assert property (ce_i && st_reg.ax[0].pend_stop &&
    st_reg.ax[0].running && entry_done_i[0] && !lim_up_act[0] && !lim_lo_act[0]
    |=> imm_stop_o[0] && !running_o[0]) else $error("path stop missed"); // [R4]

  c_start_ok: cover property (start_ok_o);
  c_start_err: cover property (start_err_o);
  c_limit_stop: cover property (decel_stop_o[0] && limit_hold_o[0]);
  c_path_stop: cover property (st_reg.ax[0].pend_stop ##[1:20] imm_stop_o[0]);

endmodule

`default_nettype wire

// ---- bench/asl_far_model.sv ----
// Purpose: machine side limit switches of two axes
// Assumes: b-contact switches, closed means pin tied to common
// Notes:   an unwired pin reads as open, like a tripped switch
`timescale 1ns/10ps
`default_nettype none

module asl_far_model (
  input  wire logic [1:0] wired_i,
  input  wire logic [1:0] trip_up_i,
  input  wire logic [1:0] trip_lo_i,
  output logic      [1:0] upper_pin_o,
  output logic      [1:0] lower_pin_o
);
  // open contact and missing wire look the same, which is the hazard
  assign upper_pin_o = wired_i & ~trip_up_i;
  assign lower_pin_o = wired_i & ~trip_lo_i;
endmodule

`default_nettype wire

// ---- bench/test_axis_stroke_limit_checker.sv ----
// Purpose: self-checking bench of the stroke limit checker, two axes
// Assumes: inputs change at the falling edge, outputs sampled there
// Notes:   host parameter loads go through a host ready rise
`timescale 1ns/10ps
`default_nettype none

module test_axis_stroke_limit_checker;
  import asl_pkg::*;
  typedef struct packed {asl_kind_t k; logic [1:0] m; logic d; logic ok;} asl_row_t;
  logic clock_i = 1'b0;
  logic rst_i = 1'b1;
  logic ce_i = 1'b1;
  logic hr, cq, ca, sok, ser, cok, cer;
  logic [1:0] sax, spd, ed, re, run, dec, imm, hold, upin, lpin, wired, tup, tlo;
  logic [1:0][31:0] fs, cfv;
  logic [31:0] cv;
  asl_param_t [1:0] prm;
  asl_start_t st;
  asl_row_t rows [7];
  int mismatches = 0;
  int checks = 0;
  int n;

  asl_far_model asl_far_model_i (.wired_i(wired), .trip_up_i(tup), .trip_lo_i(tlo),
    .upper_pin_o(upin), .lower_pin_o(lpin));
  asl_checker #(.NUM_AXES(2)) asl_checker_i (.clock_i(clock_i), .rst_i(rst_i), .ce_i(ce_i),
    .host_ready_i(hr), .param_i(prm), .upper_limit_input_i(upin),
    .lower_limit_input_i(lpin), .start_i(st), .start_axes_i(sax), .speed_phase_i(spd),
    .entry_done_i(ed), .run_end_i(re), .feed_step_i(fs), .chg_req_i(cq), .chg_axis_i(ca),
    .chg_value_i(cv), .start_ok_o(sok), .start_err_o(ser), .chg_ok_o(cok),
    .chg_err_o(cer), .running_o(run), .decel_stop_o(dec), .imm_stop_o(imm),
    .limit_hold_o(hold), .current_feed_value_o(cfv));

  // free running clock
  always begin
    #25 clock_i = ~clock_i;
  end

  // ****************************************************************
  // helpers
  // ****************************************************************
  task automatic tick();
    @(negedge clock_i);
  endtask

  task automatic chk(string nm, logic [31:0] seen, logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      mismatches++;
      $display("[ERR] %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  function automatic asl_param_t mk(logic signed [31:0] u, l, logic m, pl, dg);
    mk = '{u, l, 1'b0, m, 1'b1, pl, pl, dg};
  endfunction

  // host ready must be low at one enabled edge before it rises
  task automatic load(asl_param_t p0, p1);
    prm = '{p1, p0};
    hr = 1'b0;
    tick();
    hr = 1'b1;
    tick();
  endtask

  task automatic start(asl_kind_t k, logic [1:0] m, logic d, logic ok);
    st = '{1'b1, k, d};
    sax = m;
    tick();
    st.req = 1'b0;
    chk("start ok", sok, ok);
    chk("start err", ser, !ok);
    chk("running", run, ok ? m : 2'h0);
    // request stays low across one edge before the next one
    tick();
  endtask

  task automatic chg(logic a, logic [31:0] v, logic ok);
    cq = 1'b1;
    ca = a;
    cv = v;
    tick();
    cq = 1'b0;
    chk("chg ok", cok, ok);
    chk("chg err", cer, !ok);
    tick();
  endtask

  task automatic stop(logic [1:0] m);
    re = m;
    tick();
    re = 2'h0;
    tick();
  endtask

  // axis 0 runs upward from zero and crosses the upper bound
  task automatic run_case(asl_kind_t k, logic e_dec, logic e_imm, logic e_pend);
    logic sd = 1'b0;
    logic si = 1'b0;
    logic sp = 1'b0;
    chg(1'b0, 32'h0, 1'b1);
    start(k, 2'h1, 1'b1, 1'b1);
    fs[0] = 32'h64;
    repeat (20) begin
      tick();
      sd |= dec[0];
      si |= imm[0];
    end
    ed = 2'h1;
    // the stop pulse stands right after the entry edge, so look there too
    repeat (2) begin
      tick();
      ed = 2'h0;
      sp |= imm[0];
    end
    fs[0] = 32'h0;
    stop(2'h1);
    chk("decel", sd, e_dec);
    chk("imm", si, e_imm);
    chk("entry imm", sp, e_pend);
    $display("test run kind %0d done", k);
  endtask

  task automatic conclude();
    $display("comparisons %0d mismatches %0d", checks, mismatches);
    if (mismatches == 0 && checks > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask

  // watchdog, the whole sequence needs well under 1000 cycles
  initial begin
    #(5000 * 50);
    mismatches++;
    conclude();
  end

  // ****************************************************************
  // main sequence
  // ****************************************************************
  initial begin
    {hr, cq, ca, cv, st, sax, spd, ed, re, fs, tup, tlo} = '0;
    wired = 2'h3;
    prm = '{mk(32'sh3e8, -32'sh3e8, 1'b0, 1'b0, 1'b0), mk(32'sh3e8, -32'sh3e8, 1'b0, 1'b0, 1'b0)};
    rows = '{'{ASL_K_ORIGIN, 2'h1, 1'b0, 1'b1}, '{ASL_K_POSITION, 2'h3, 1'b0, 1'b1},
      '{ASL_K_SPEED, 2'h2, 1'b0, 1'b1}, '{ASL_K_CIRCULAR, 2'h3, 1'b0, 1'b1},
      '{ASL_K_CONTPATH, 2'h1, 1'b0, 1'b1}, '{ASL_K_MANUAL, 2'h1, 1'b1, 1'b1},
      '{ASL_K_POSITION, 2'h0, 1'b0, 1'b0}};
    repeat (3) tick();
    rst_i = 1'b0;
    repeat (3) tick();
    chg(1'b1, 32'h7fffffff, 1'b1);
    chg(1'b1, 32'h80000000, 1'b1);
    chg(1'b1, 32'h0, 1'b1);
    $display("test reset bounds done");
    load(mk(32'sh3e8, -32'sh3e8, 1'b0, 1'b0, 1'b0), mk(32'sha, -32'sha, 1'b0, 1'b0, 1'b0));
    foreach (rows[i]) begin
      start(rows[i].k, rows[i].m, rows[i].d, rows[i].ok);
      stop(rows[i].m);
    end
    $display("test start table done");
    chg(1'b0, 32'h1f4, 1'b1);
    chk("feed", cfv[0], 32'h1f4);
    chg(1'b1, 32'h1f4, 1'b0);
    chg(1'b0, 32'h7d0, 1'b0);
    chk("feed kept", cfv[0], 32'h1f4);
    prm = '{mk(32'sh64, -32'sh64, 1'b0, 1'b0, 1'b0), mk(32'sh64, -32'sh64, 1'b0, 1'b0, 1'b0)};
    start(ASL_K_POSITION, 2'h1, 1'b0, 1'b1);
    stop(2'h1);
    load(prm[0], prm[1]);
    start(ASL_K_POSITION, 2'h3, 1'b0, 1'b0);
    start(ASL_K_MANUAL, 2'h1, 1'b1, 1'b0);
    start(ASL_K_MANUAL, 2'h1, 1'b0, 1'b1);
    chk("back run", run, 2'h1);
    stop(2'h1);
    load(mk(32'sh64, -32'sh64, 1'b1, 1'b0, 1'b0), prm[1]);
    start(ASL_K_MANUAL, 2'h1, 1'b1, 1'b1);
    stop(2'h1);
    start(ASL_K_POSITION, 2'h1, 1'b0, 1'b0);
    // frozen feed value in speed control skips the check
    prm[0] = mk(32'sh64, -32'sh64, 1'b0, 1'b0, 1'b0);
    prm[0].feed_value_update_in_speed_ctrl = 1'b0;
    load(prm[0], prm[1]);
    start(ASL_K_SPEED, 2'h1, 1'b0, 1'b1);
    stop(2'h1);
    load(mk(32'sh0, 32'sh0, 1'b0, 1'b0, 1'b0), prm[1]);
    start(ASL_K_POSITION, 2'h1, 1'b0, 1'b1);
    stop(2'h1);
    // clockwise span crossing the zero address
    load(mk(32'sh64, 32'sh0225_5000, 1'b0, 1'b0, 1'b1), prm[1]);
    start(ASL_K_SPEED, 2'h1, 1'b0, 1'b1);
    stop(2'h1);
    start(ASL_K_POSITION, 2'h1, 1'b0, 1'b0);
    chg(1'b0, 32'h02255100, 1'b0);
    chg(1'b0, 32'h02255080, 1'b1);
    chg(1'b0, 32'h32, 1'b1);
    $display("test settings done");
    load(mk(32'sh3e8, -32'sh3e8, 1'b0, 1'b0, 1'b0), prm[1]);
    run_case(ASL_K_POSITION, 1'b0, 1'b1, 1'b0);
    run_case(ASL_K_SPEED, 1'b1, 1'b0, 1'b0);
    run_case(ASL_K_CIRCULAR, 1'b0, 1'b0, 1'b0);
    run_case(ASL_K_CONTPATH, 1'b0, 1'b0, 1'b1);
    chg(1'b0, 32'h0, 1'b1);
    start(ASL_K_POSITION, 2'h1, 1'b0, 1'b1);
    tup = 2'h1;
    n = 0;
    while (dec[0] !== 1'b1 && n < 10) begin
      tick();
      n++;
    end
    chk("limit delay", 32'(n), 32'd3);
    chk("hold", hold, 2'h1);
    tup = 2'h0;
    repeat (3) tick();
    start(ASL_K_POSITION, 2'h1, 1'b0, 1'b0);
    start(ASL_K_MANUAL, 2'h1, 1'b1, 1'b1);
    stop(2'h1);
    chk("hold clear", hold, 2'h0);
    wired = 2'h2;
    repeat (3) tick();
    start(ASL_K_POSITION, 2'h1, 1'b0, 1'b0);
    load(mk(32'sh3e8, -32'sh3e8, 1'b0, 1'b1, 1'b0), prm[1]);
    repeat (3) tick();
    start(ASL_K_POSITION, 2'h1, 1'b0, 1'b1);
    // clock enable low freezes the running feed
    ce_i = 1'b0;
    fs[0] = 32'h1;
    repeat (3) tick();
    chk("frozen feed", cfv[0], 32'h0);
    chk("frozen run", run, 2'h1);
    ce_i = 1'b1;
    fs[0] = 32'h0;
    stop(2'h1);
    $display("test limit switches done");
    conclude();
  end
endmodule

`default_nettype wire
